// >>> include/sacc_pkg.sv
// constants and types for the converter mode and output-coding control block
`default_nettype none
package sacc_pkg;
   localparam int unsigned CLK_KHZ = 40000;
   localparam int unsigned RATE_FAST_KSPS = 750;
   localparam int unsigned RATE_NORMAL_KSPS = 600;
   localparam int unsigned RATE_LOWP_KSPS = 500;
   // least spacing between starts, rounded up to whole cycles
   localparam int unsigned SPACE_FAST = (CLK_KHZ + RATE_FAST_KSPS - 1) / RATE_FAST_KSPS;
   localparam int unsigned SPACE_NORMAL = (CLK_KHZ + RATE_NORMAL_KSPS - 1) / RATE_NORMAL_KSPS;
   localparam int unsigned SPACE_LOWP = (CLK_KHZ + RATE_LOWP_KSPS - 1) / RATE_LOWP_KSPS;
   localparam int unsigned IDLE_GAP_MS = 1;
   localparam int unsigned IDLE_GAP_CYCLES = IDLE_GAP_MS * CLK_KHZ;
   localparam int unsigned CONV_CYCLES_DEF = 40;
   localparam int unsigned SPACE_W = 8;

   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_RESULT = 4'h8;
   localparam int unsigned CFG_W = 6;
   localparam int unsigned CFG_OVR_BIT = 0;
   localparam int unsigned CFG_BINARY_BIT = 1;
   localparam int unsigned CFG_SIGNED_BIT = 2;
   localparam int unsigned CFG_WIDE_BIT = 3;
   localparam int unsigned CFG_FAST_BIT = 4;
   localparam int unsigned CFG_LOWP_BIT = 5;
   localparam logic [5:0] CFG_RESET = 6'h00;
   localparam int unsigned ST_BUSY_BIT = 0;
   localparam int unsigned ST_MODE_LSB = 1;
   localparam int unsigned ST_STALE_BIT = 4;
   localparam int unsigned ST_BINARY_BIT = 5;
   localparam int unsigned ST_SIGNED_BIT = 6;
   localparam int unsigned ST_WIDE_BIT = 7;
   localparam int unsigned ST_PWRDN_BIT = 8;

   localparam logic [15:0] SB_MAX = 16'hFFFF;
   localparam logic [15:0] SB_MIN = 16'h0000;
   localparam logic [15:0] TC_MAX = 16'h7FFF;
   localparam logic [15:0] TC_MIN = 16'h8000;
   localparam logic [15:0] MSB_FLIP = 16'h8000;

   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b001,
      MODE_FAST = 3'b010,
      MODE_LOWP = 3'b100
   } sacc_mode_type;

   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_CONV = 2'b10
   } sacc_state_type;

   typedef struct packed {
      logic fast;
      logic lowPower;
      logic binary;
      logic signedRange;
      logic wideRange;
   } sacc_cfg_type;

   typedef struct packed {
      logic fastModeSelect;
      logic lowPowerModeSelect;
      logic outputCodingSelect;
      logic signedRangeSelect;
      logic wideRangeSelect;
      logic refPowerdown;
      logic refBufferPowerdown;
      logic convertStartN;
   } sacc_pins_type;

   typedef struct packed {
      logic bandgapEn;
      logic refBufEn;
      logic tempSensorEn;
   } sacc_ref_type;
endpackage : sacc_pkg
`default_nettype wire

// >>> rtl/sacc_top.sv
// mode decode, conversion sequencing and output coding of the sample converter
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`default_nettype none
module sacc_top #(
   parameter int unsigned CONV_CYCLES = sacc_pkg::CONV_CYCLES_DEF,
   parameter int unsigned GAP_CYCLES = sacc_pkg::IDLE_GAP_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire sacc_pkg::sacc_pins_type pinsIn,
   input wire logic [15:0] sarCode,
   input wire logic overHigh,
   input wire logic overLow,
   input wire logic [sacc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic busy,
   output logic [15:0] resultCode,
   output logic resultValid,
   output logic resultStale,
   output sacc_pkg::sacc_mode_type activeMode,
   output logic rangeSigned,
   output logic rangeWide,
   output logic convPowerDown,
   output sacc_pkg::sacc_ref_type refEnables
);
   import sacc_pkg::*;
   localparam int unsigned GAP_W = $clog2(GAP_CYCLES + 1);
   localparam int unsigned CONV_W = $clog2(CONV_CYCLES + 1);

   logic [7:0] syncA_r;
   logic [7:0] syncB_r;
   sacc_pins_type pins;
   logic convNPrev_r;
   logic [CFG_W-1:0] cfgReg_r;
   sacc_cfg_type cfgSel;
   sacc_cfg_type activeCfg_r;
   sacc_state_type state_r;
   logic [CONV_W-1:0] convCnt_r;
   logic [SPACE_W-1:0] spaceCnt_r;
   logic [GAP_W-1:0] gapCnt_r;
   logic staleNext_r;
   logic startTaken;
   logic convDone;
   sacc_mode_type selMode;

   function automatic sacc_mode_type decodeMode(input logic fast, input logic lowPower);
      unique case ({fast, lowPower})
         2'b10: decodeMode = MODE_FAST;
         2'b01: decodeMode = MODE_LOWP;
         2'b00, 2'b11: decodeMode = MODE_NORMAL;
      endcase
   endfunction : decodeMode

   function automatic logic [SPACE_W-1:0] spacingFor(input sacc_mode_type m);
      unique case (m)
         MODE_FAST: spacingFor = SPACE_W'(SPACE_FAST);
         MODE_LOWP: spacingFor = SPACE_W'(SPACE_LOWP);
         default: spacingFor = SPACE_W'(SPACE_NORMAL);
      endcase
   endfunction : spacingFor

   // select pins are static straps from the host and the start pin is a strobe; all are asynchronous to clk_sys
   for (genvar i = 0; i < 8; i++) begin : g_sync
      always_ff @(posedge clk_sys or negedge nrst) begin
         if (!nrst) begin
            syncA_r[i] <= 1'b1;
            syncB_r[i] <= 1'b1;
         end else begin
            syncA_r[i] <= pinsIn[i];
            syncB_r[i] <= syncA_r[i];
         end
      end
   end
   assign pins = sacc_pins_type'(syncB_r);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         convNPrev_r <= 1'b1;
      end else begin
         convNPrev_r <= pins.convertStartN;
      end
   end

   // software override wins; the select pins are then don't-cares
   always_comb begin
      if (cfgReg_r[CFG_OVR_BIT]) begin
         cfgSel.fast = cfgReg_r[CFG_FAST_BIT];
         cfgSel.lowPower = cfgReg_r[CFG_LOWP_BIT];
         cfgSel.binary = cfgReg_r[CFG_BINARY_BIT];
         cfgSel.signedRange = cfgReg_r[CFG_SIGNED_BIT];
         cfgSel.wideRange = cfgReg_r[CFG_WIDE_BIT];
      end else begin
         cfgSel.fast = pins.fastModeSelect;
         cfgSel.lowPower = pins.lowPowerModeSelect;
         cfgSel.binary = pins.outputCodingSelect;
         cfgSel.signedRange = pins.signedRangeSelect;
         cfgSel.wideRange = pins.wideRangeSelect;
      end
   end
   assign selMode = decodeMode(cfgSel.fast, cfgSel.lowPower);

   // starts arriving before the mode's least spacing are dropped, not queued
   assign startTaken = convNPrev_r && !pins.convertStartN && state_r == S_IDLE
      && spaceCnt_r == '0;
   assign convDone = state_r == S_CONV && convCnt_r == '0;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_r <= S_IDLE;
         convCnt_r <= '0;
      end else if (startTaken) begin
         state_r <= S_CONV;
         convCnt_r <= CONV_W'(CONV_CYCLES - 1);
      end else if (convDone) begin
         state_r <= S_IDLE;
      end else if (state_r == S_CONV) begin
         convCnt_r <= convCnt_r - 1'b1;
      end
   end

   // configuration latches at each sample, so a change needs no reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         activeCfg_r <= '0;
      end else if (startTaken) begin
         activeCfg_r <= cfgSel;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         spaceCnt_r <= '0;
      end else if (startTaken) begin
         spaceCnt_r <= spacingFor(selMode) - 1'b1;
      end else if (spaceCnt_r != '0) begin
         spaceCnt_r <= spaceCnt_r - 1'b1;
      end
   end

   // background calibration drifts when idle; counter starts at zero after reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gapCnt_r <= '0;
         staleNext_r <= 1'b0;
      end else if (startTaken) begin
         gapCnt_r <= '0;
         staleNext_r <= selMode == MODE_FAST && gapCnt_r >= GAP_W'(GAP_CYCLES);
      end else if (gapCnt_r < GAP_W'(GAP_CYCLES)) begin
         gapCnt_r <= gapCnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         resultCode <= SB_MIN;
         resultValid <= 1'b0;
         resultStale <= 1'b0;
      end else begin
         resultValid <= convDone;
         if (convDone) begin
            resultStale <= staleNext_r;
            if (overHigh) begin
               resultCode <= activeCfg_r.binary ? SB_MAX : TC_MAX;
            end else if (overLow) begin
               resultCode <= activeCfg_r.binary ? SB_MIN : TC_MIN;
            end else begin
               resultCode <= activeCfg_r.binary ? sarCode : sarCode ^ MSB_FLIP;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         convPowerDown <= 1'b0;
      end else if (startTaken) begin
         convPowerDown <= 1'b0;
      end else if (convDone && activeMode == MODE_LOWP) begin
         convPowerDown <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         refEnables <= '0;
      end else begin
         refEnables.bandgapEn <= !pins.refPowerdown;
         refEnables.tempSensorEn <= !pins.refPowerdown;
         refEnables.refBufEn <= !pins.refBufferPowerdown;
      end
   end

   assign busy = state_r == S_CONV;
   assign activeMode = decodeMode(activeCfg_r.fast, activeCfg_r.lowPower);
   assign rangeSigned = activeCfg_r.signedRange;
   assign rangeWide = activeCfg_r.wideRange;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cfgReg_r <= CFG_RESET;
      end else if (regWr && regAddr == ADDR_CONFIG) begin
         cfgReg_r <= regWdata[CFG_W-1:0];
      end
   end

   // read data stands for one cycle only; unmapped addresses read zero
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         regRdata <= '0;
      end else begin
         regRdata <= '0;
         if (regRd) begin
            unique case (regAddr)
               ADDR_CONFIG: regRdata <= {26'h0, cfgReg_r};
               ADDR_STATUS: begin
                  regRdata[ST_BUSY_BIT] <= busy;
                  regRdata[ST_MODE_LSB +: 3] <= activeMode;
                  regRdata[ST_STALE_BIT] <= resultStale;
                  regRdata[ST_BINARY_BIT] <= activeCfg_r.binary;
                  regRdata[ST_SIGNED_BIT] <= activeCfg_r.signedRange;
                  regRdata[ST_WIDE_BIT] <= activeCfg_r.wideRange;
                  regRdata[ST_PWRDN_BIT] <= convPowerDown;
               end
               ADDR_RESULT: regRdata <= {16'h0, resultCode};
               default: regRdata <= '0;
            endcase
         end
      end
   end
   // helper: start-to-start distance, the taken edge counted as cycle one
   logic [SPACE_W-1:0] sinceStart_r;
   logic [SPACE_W-1:0] lastSpace_r;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sinceStart_r <= '1;
         lastSpace_r <= '0;
      end else if (startTaken) begin
         sinceStart_r <= SPACE_W'(1);
         lastSpace_r <= spacingFor(selMode);
      end else if (sinceStart_r != '1) begin
         sinceStart_r <= sinceStart_r + 1'b1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   property p_normal_decode;
      activeCfg_r.fast == activeCfg_r.lowPower |-> activeMode == MODE_NORMAL;
   endproperty
   a_normal_decode: assert property (p_normal_decode) else $error("mode pins equal not normal");
   property p_lowp_powerdown;
      convDone && activeMode == MODE_LOWP |=> convPowerDown && resultValid;
   endproperty
   a_lowp_powerdown: assert property (p_lowp_powerdown) else $error("no power down");
   property p_spacing;
      startTaken |-> sinceStart_r >= lastSpace_r;
   endproperty
   a_spacing: assert property (p_spacing) else $error("start inside spacing");
   property p_coding;
      convDone && !overHigh && !overLow |=>
         resultCode == ($past(activeCfg_r.binary) ? $past(sarCode) : $past(sarCode) ^ MSB_FLIP);
   endproperty
   a_coding: assert property (p_coding) else $error("wrong output coding");
   property p_sat_high;
      convDone && overHigh |=> resultCode == ($past(activeCfg_r.binary) ? SB_MAX : TC_MAX);
   endproperty
   a_sat_high: assert property (p_sat_high) else $error("no high saturation");
   property p_override;
      startTaken && cfgReg_r[CFG_OVR_BIT] |=>
         activeCfg_r.binary == $past(cfgReg_r[CFG_BINARY_BIT])
         && rangeWide == $past(cfgReg_r[CFG_WIDE_BIT]);
   endproperty
   a_override: assert property (p_override) else $error("pins not ignored");
   property p_pin_range;
      startTaken && !cfgReg_r[CFG_OVR_BIT] |=>
         rangeSigned == $past(pins.signedRangeSelect) && rangeWide == $past(pins.wideRangeSelect);
   endproperty
   a_pin_range: assert property (p_pin_range) else $error("range pins not used");
   property p_ref_enable;
      !pins.refPowerdown && !pins.refBufferPowerdown |=> refEnables == 3'b111;
   endproperty
   a_ref_enable: assert property (p_ref_enable) else $error("reference not enabled");
   property p_busy_end;
      $fell(busy) |-> resultValid ##1 !resultValid;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy fell without result");
   property p_onehot_mode;
      $onehot(activeMode);
   endproperty
   a_onehot_mode: assert property (p_onehot_mode) else $error("mode not one-hot");
   property p_stale_fast;
      resultValid && resultStale |-> activeMode == MODE_FAST;
   endproperty
   a_stale_fast: assert property (p_stale_fast) else $error("stale outside fast mode");
   c_lowp: cover property (convDone && activeMode == MODE_LOWP);
   c_stale: cover property (resultValid && resultStale);
   c_over: cover property (convDone && overLow && !activeCfg_r.binary);
   c_sw: cover property (startTaken && cfgReg_r[CFG_OVR_BIT]);
endmodule : sacc_top
`default_nettype wire

// >>> verif/sacc_host_model.sv
// host-side model: static select pins and the convert start strobe
`default_nettype none
module sacc_host_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [6:0] levels,
   input wire logic startReq,
   output var sacc_pkg::sacc_pins_type pinsOut
);
   timeunit 1ns;
   timeprecision 1ps;
   import sacc_pkg::*;
   logic [2:0] lowCnt_r;
   logic startN_r;
   // pins unused under override are still held at fixed levels
   assign pinsOut = {levels, startN_r};
   // start held low four cycles so the pin synchroniser cannot miss it
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         startN_r <= 1'b1;
         lowCnt_r <= 3'h0;
      end else if (startReq) begin
         startN_r <= 1'b0;
         lowCnt_r <= 3'h4;
      end else if (lowCnt_r != 3'h0) begin
         lowCnt_r <= lowCnt_r - 3'h1;
         startN_r <= (lowCnt_r == 3'h1);
      end
   end
endmodule : sacc_host_model
`default_nettype wire

// >>> verif/sacc_top_tb.sv
// self-checking bench for the converter mode and coding control block
`default_nettype none
module sacc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sacc_pkg::*;
   localparam int CONV = 20;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [6:0] levels = 7'h20;
   logic startReq = 1'b0;
   sacc_pins_type pinsIn;
   logic [15:0] sarCode = 16'h0000;
   logic overHigh = 1'b0;
   logic overLow = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic busy, resultValid, resultStale, rangeSigned, rangeWide, convPowerDown;
   logic [15:0] resultCode;
   sacc_mode_type activeMode;
   sacc_ref_type refEnables;
   int n_fail = 0;
   int samples_checked = 0;
   logic st;
   logic [31:0] rv;

   sacc_host_model HOST (.clk_sys(clk_sys), .nrst(nrst), .levels(levels),
      .startReq(startReq), .pinsOut(pinsIn));
   sacc_top #(.CONV_CYCLES(CONV), .GAP_CYCLES(100)) DUT (.clk_sys(clk_sys), .nrst(nrst),
      .pinsIn(pinsIn), .sarCode(sarCode), .overHigh(overHigh), .overLow(overLow),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .busy(busy), .resultCode(resultCode),
      .resultValid(resultValid), .resultStale(resultStale), .activeMode(activeMode),
      .rangeSigned(rangeSigned), .rangeWide(rangeWide), .convPowerDown(convPowerDown),
      .refEnables(refEnables));

   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask : rd

   task automatic kick();
      @(posedge clk_sys);
      startReq <= 1'b1;
      @(posedge clk_sys);
      startReq <= 1'b0;
   endtask : kick

   // one conversion: busy length, completion pulse and coded result
   task automatic conv(input logic [15:0] raw, input logic oh, input logic ol,
                       input logic [15:0] exp, output logic stale);
      int n;
      n = 0;
      sarCode <= raw;
      overHigh <= oh;
      overLow <= ol;
      kick();
      while (busy !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      chk(n, CONV, "busy length");
      chk(resultValid, 1'b1, "valid at busy fall");
      chk(resultCode, exp, "result code");
      stale = resultStale;
   endtask : conv

   task automatic t_ref();
      cyc(5);
      chk(refEnables, 3'b111, "reference on");
      levels[1:0] <= 2'b11;
      cyc(5);
      chk(refEnables, 3'b000, "reference off");
      levels[1:0] <= 2'b00;
   endtask : t_ref

   task automatic t_modes();
      sacc_mode_type exp[4] = '{MODE_NORMAL, MODE_LOWP, MODE_FAST, MODE_NORMAL};
      for (int i = 0; i < 4; i++) begin
         levels[6:5] <= 2'(i);
         cyc(90);
         // coding pin is low here, so twos complement flips the top bit
         conv(16'h1234, 1'b0, 1'b0, 16'h9234, st);
         chk(activeMode, exp[i], "mode decode");
         chk(convPowerDown, i == 1, "power down after conversion");
         if (i == 1) begin
            // restart well inside the low-power spacing must be dropped
            kick();
            cyc(12);
            chk(busy, 1'b0, "early start dropped");
         end
      end
   endtask : t_modes

   task automatic t_coding();
      logic [34:0] tbl[8] = '{{16'h8000, 3'b001, 16'h8000}, {16'h8000, 3'b000, 16'h0000},
         {16'h7FFF, 3'b000, 16'hFFFF}, {16'h1234, 3'b101, 16'hFFFF},
         {16'h1234, 3'b100, 16'h7FFF}, {16'h1234, 3'b011, 16'h0000},
         {16'h1234, 3'b010, 16'h8000}, {16'h0000, 3'b110, 16'h7FFF}};
      levels[6:5] <= 2'b00;
      for (int i = 0; i < 8; i++) begin
         levels[4] <= tbl[i][16];
         cyc(90);
         conv(tbl[i][34:19], tbl[i][18], tbl[i][17], tbl[i][15:0], st);
      end
   endtask : t_coding

   task automatic t_stale();
      levels[6:5] <= 2'b10;
      cyc(120);
      // coding pin still low from the last coding entry: twos complement
      conv(16'h4000, 1'b0, 1'b0, 16'hC000, st);
      chk(st, 1'b1, "stale after idle gap");
      cyc(40);
      conv(16'h4000, 1'b0, 1'b0, 16'hC000, st);
      chk(st, 1'b0, "fresh result");
   endtask : t_stale

   task automatic t_regs();
      levels <= 7'h10;
      wr(4'h0, 32'h0000001D);
      wr(4'hC, 32'h0000003F);
      rd(4'h0, rv);
      chk(rv, 32'h1D, "config readback");
      rd(4'hC, rv);
      chk(rv, 32'h0, "unmapped read");
      cyc(90);
      conv(16'h8001, 1'b0, 1'b0, 16'h0001, st);
      chk({activeMode, rangeSigned, rangeWide}, {MODE_FAST, 2'b11}, "override");
      rd(4'h8, rv);
      chk(rv[15:0], 16'h0001, "result register");
      // status without the stale bit: fast, twos, signed, wide, idle, powered
      rd(4'h4, rv);
      chk({rv[8:5], rv[3:0]}, 8'h64, "status register");
      wr(4'h0, 32'h0);
      levels <= 7'h18;
      cyc(90);
      conv(16'h8001, 1'b0, 1'b0, 16'h8001, st);
      chk({rangeSigned, rangeWide}, 2'b10, "pin ranges");
   endtask : t_regs

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      #1;
      chk(activeMode, MODE_NORMAL, "reset mode");
      t_ref();
      t_modes();
      t_coding();
      t_stale();
      t_regs();
      summarize();
   end

   initial begin
      #(25 * 20000);
      n_fail++;
      summarize();
   end
endmodule : sacc_top_tb
`default_nettype wire
